/* File: pix_fix_regs_pkg.sv */
// constants and carrier types for the pixel-correction register bank
// assumes one register-bus clock; the datapath sits outside this bank

package pix_fix_regs_pkg;

	// =====================================================
	// register offsets
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ERRORS = 12'h008;
	localparam logic [11:0] OFF_MASK = 12'h00c;
	localparam logic [11:0] OFF_VERSION = 12'h010;
	localparam logic [11:0] OFF_FRAMES = 12'h014;
	localparam logic [11:0] OFF_LINES = 12'h018;
	localparam logic [11:0] OFF_PIXELS = 12'h01c;
	localparam logic [11:0] OFF_DIMS = 12'h020;
	localparam logic [11:0] OFF_STUCK = 12'h100;
	localparam logic [11:0] OFF_OUTLIER = 12'h104;
	localparam logic [11:0] OFF_AGE = 12'h108;
	localparam logic [11:0] OFF_CANDS = 12'h10c;
	localparam logic [11:0] OFF_FIXED = 12'h120;

	// =====================================================
	// field positions
	localparam int CTL_RUN = 0;
	localparam int CTL_UPD = 1;
	localparam int CTL_BYP = 4;
	localparam int CTL_TPG = 5;
	localparam int CTL_FSR = 30;
	localparam int CTL_SRST = 31;
	localparam logic [31:0] CTL_WMASK_BASE = 32'hc000_0003;
	localparam logic [31:0] CTL_WMASK_DBG = 32'h0000_0030;
	localparam int STS_BEGUN = 0;
	localparam int STS_DONE = 1;
	localparam int STS_ERR = 16;
	localparam int FLAG_W = 17;
	localparam int ERR_W = 4;
	localparam int EV_W = 9;
	localparam int EV_BEGUN = 0;
	localparam int EV_DONE = 1;
	localparam int EV_ERR = 4;
	localparam int EV_SHORT = 5;
	localparam int DIM_W = 13;
	localparam int LINE_LSB = 16;
	localparam int STUCK_W = 12;
	localparam int THR_W = 16;
	localparam int CNT_W = 14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =====================================================
	// carrier types
	typedef struct packed {
		logic [12:0] width;
		logic [12:0] height;
		logic [11:0] stuck;
		logic [15:0] outlier;
		logic [15:0] age;
	} cfg_t;

	typedef struct packed {
		logic aw_rdy;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] control;
		logic [16:0] status;
		logic [3:0] errors;
		logic [16:0] mask;
		cfg_t proc;
		cfg_t act;
		logic [31:0] frames;
		logic [31:0] lines;
		logic [31:0] pixels;
		logic [31:0] cands;
		logic [31:0] fixed;
		logic in_frame;
		logic [13:0] pix;
		logic [13:0] line;
		logic [8:0] events;
		logic irq;
		logic core_rst;
	} state_t;

endpackage : pix_fix_regs_pkg

/* File: video_pixel_fix_ctrl_regs.sv */
// register bank, frame monitor and interrupt logic of the pixel-correction core
// assumes the register bus and the stream monitor share clk; rst is synchronous

`timescale 1ns/1ps
`default_nettype none

module video_pixel_fix_ctrl_regs #(
	parameter bit DEBUG_EN = 1'b1,
	parameter logic [31:0] VERSION_ID = 32'h0100_0000, // arbitrary value
	parameter logic [12:0] DEF_WIDTH = 13'd1920,
	parameter logic [12:0] DEF_HEIGHT = 13'd1080,
	parameter logic [11:0] DEF_STUCK = 12'd16,
	parameter logic [15:0] DEF_OUTLIER = 16'd64,
	parameter logic [15:0] DEF_AGE = 16'd1000
) (
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// stream monitor taps
	input wire logic mon_beat,
	input wire logic mon_sof,
	input wire logic mon_eol,
	// datapath counts of the frame just ended
	input wire logic [31:0] cand_count_in,
	input wire logic [31:0] fixed_count_in,
	// to the datapath and host
	output pix_fix_regs_pkg::cfg_t active_cfg,
	output logic software_run_bit,
	output logic bypass_mode,
	output logic test_pattern_mode,
	output logic core_reset,
	output logic irq,
	output logic [8:0] parallel_event_vector
);

	// =====================================================
	// constants
	localparam pix_fix_regs_pkg::cfg_t DEF_CFG = '{
		width: DEF_WIDTH,
		height: DEF_HEIGHT,
		stuck: DEF_STUCK,
		outlier: DEF_OUTLIER,
		age: DEF_AGE
	};
	// debug-only control bits vanish without debug
	localparam logic [31:0] CTL_WMASK = pix_fix_regs_pkg::CTL_WMASK_BASE |
		(DEBUG_EN ? pix_fix_regs_pkg::CTL_WMASK_DBG : 32'h0);

	// =====================================================
	// functions
	// true for every printed offset
	function automatic logic mapped(input logic [11:0] a);
		mapped = 1'b1;
		case (a)
			pix_fix_regs_pkg::OFF_CONTROL, pix_fix_regs_pkg::OFF_STATUS,
			pix_fix_regs_pkg::OFF_ERRORS, pix_fix_regs_pkg::OFF_MASK,
			pix_fix_regs_pkg::OFF_VERSION, pix_fix_regs_pkg::OFF_FRAMES,
			pix_fix_regs_pkg::OFF_LINES, pix_fix_regs_pkg::OFF_PIXELS,
			pix_fix_regs_pkg::OFF_DIMS, pix_fix_regs_pkg::OFF_STUCK,
			pix_fix_regs_pkg::OFF_OUTLIER, pix_fix_regs_pkg::OFF_AGE,
			pix_fix_regs_pkg::OFF_CANDS, pix_fix_regs_pkg::OFF_FIXED: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// sticky flags: set wins over a write-one clear
	function automatic logic [16:0] w1c(input logic [16:0] old, input logic [16:0] set,
		input logic [16:0] clr);
		w1c = (old & ~clr) | set;
	endfunction : w1c

	// =====================================================
	// state
	pix_fix_regs_pkg::state_t s; // registered state
	pix_fix_regs_pkg::state_t next_s; // next state

	logic wr_fire; // write taken this cycle
	logic rd_fire; // read taken this cycle
	logic [11:0] waddr; // write offset
	logic [11:0] raddr; // read offset
	logic go; // monitor allowed to run
	logic beat; // accepted beat
	logic [13:0] pcnt; // pixels in line incl. this beat
	logic [13:0] line_n; // lines incl. this one
	logic [13:0] w14; // active width, widened
	logic [13:0] h14; // active height, widened
	logic ev_begun; // frame start
	logic ev_done; // frame complete
	logic [3:0] err_ev; // framing errors this beat
	logic reset_now; // core reset this cycle

	assign wr_fire = s.aw_rdy;
	assign rd_fire = s.ar_rdy;
	assign waddr = s_axi_awaddr[11:0];
	assign raddr = s_axi_araddr[11:0];
	assign go = s.control[pix_fix_regs_pkg::CTL_RUN] && !s.control[pix_fix_regs_pkg::CTL_SRST];
	assign beat = go && mon_beat;
	assign pcnt = (mon_sof ? 14'h0 : s.pix) + 14'h1;
	assign line_n = (mon_sof ? 14'h0 : s.line) + 14'h1;
	assign w14 = {1'b0, s.act.width};
	assign h14 = {1'b0, s.act.height};
	assign ev_begun = beat && mon_sof;
	assign ev_done = beat && mon_eol && line_n == h14;
	// error bits 3..0: late start, early start, long line, short line
	assign err_ev = {beat && mon_eol && line_n > h14,
		beat && mon_sof && s.in_frame,
		beat && pcnt > w14,
		beat && mon_eol && pcnt < w14};
	// frame-synchronised reset waits for the gap between frames
	assign reset_now = s.control[pix_fix_regs_pkg::CTL_SRST] ||
		(s.control[pix_fix_regs_pkg::CTL_FSR] && !s.in_frame && !ev_begun);

	// =====================================================
	// read mux
	function automatic logic [31:0] rd_word(input pix_fix_regs_pkg::state_t st,
		input logic [11:0] a);
		rd_word = 32'h0;
		case (a)
			pix_fix_regs_pkg::OFF_CONTROL: rd_word = st.control;
			pix_fix_regs_pkg::OFF_STATUS: rd_word = {15'h0, st.status};
			pix_fix_regs_pkg::OFF_ERRORS: rd_word = {28'h0, st.errors};
			pix_fix_regs_pkg::OFF_MASK: rd_word = {15'h0, st.mask};
			pix_fix_regs_pkg::OFF_VERSION: rd_word = VERSION_ID;
			pix_fix_regs_pkg::OFF_FRAMES: rd_word = st.frames;
			pix_fix_regs_pkg::OFF_LINES: rd_word = st.lines;
			pix_fix_regs_pkg::OFF_PIXELS: rd_word = st.pixels;
			pix_fix_regs_pkg::OFF_DIMS: rd_word = {3'h0, st.proc.height, 3'h0, st.proc.width};
			pix_fix_regs_pkg::OFF_STUCK: rd_word = {20'h0, st.proc.stuck};
			pix_fix_regs_pkg::OFF_OUTLIER: rd_word = {16'h0, st.proc.outlier};
			pix_fix_regs_pkg::OFF_AGE: rd_word = {16'h0, st.proc.age};
			pix_fix_regs_pkg::OFF_CANDS: rd_word = st.cands;
			pix_fix_regs_pkg::OFF_FIXED: rd_word = st.fixed;
			default: rd_word = 32'h0;
		endcase
	endfunction : rd_word

	// =====================================================
	// next state
	always_comb begin
		logic [16:0] sts_set;
		logic [16:0] sts_clr;
		logic [16:0] err_clr;
		sts_set = '0;
		sts_clr = '0;
		err_clr = '0;
		next_s = s;

		// write channel: ready pulses once both halves wait
		next_s.aw_rdy = s_axi_awvalid && s_axi_wvalid && !s.aw_rdy && !s.bvalid;
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = mapped(waddr) ? pix_fix_regs_pkg::RESP_OKAY : pix_fix_regs_pkg::RESP_SLVERR;
		end

		// read channel: data latched on the ready cycle
		next_s.ar_rdy = s_axi_arvalid && !s.ar_rdy && !s.rvalid;
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = mapped(raddr) ? pix_fix_regs_pkg::RESP_OKAY : pix_fix_regs_pkg::RESP_SLVERR;
			next_s.rdata = rd_word(s, raddr);
		end

		// register writes; shadow set only, active set waits for frame end
		if (wr_fire) begin
			case (waddr)
				pix_fix_regs_pkg::OFF_CONTROL: next_s.control = s_axi_wdata & CTL_WMASK;
				pix_fix_regs_pkg::OFF_STATUS: sts_clr = s_axi_wdata[pix_fix_regs_pkg::FLAG_W-1:0];
				pix_fix_regs_pkg::OFF_ERRORS: err_clr = {13'h0, s_axi_wdata[pix_fix_regs_pkg::ERR_W-1:0]};
				pix_fix_regs_pkg::OFF_MASK: next_s.mask = s_axi_wdata[pix_fix_regs_pkg::FLAG_W-1:0];
				pix_fix_regs_pkg::OFF_DIMS: begin
					next_s.proc.width = s_axi_wdata[pix_fix_regs_pkg::DIM_W-1:0];
					next_s.proc.height = s_axi_wdata[pix_fix_regs_pkg::LINE_LSB +: pix_fix_regs_pkg::DIM_W];
				end
				pix_fix_regs_pkg::OFF_STUCK: next_s.proc.stuck = s_axi_wdata[pix_fix_regs_pkg::STUCK_W-1:0];
				pix_fix_regs_pkg::OFF_OUTLIER: next_s.proc.outlier = s_axi_wdata[pix_fix_regs_pkg::THR_W-1:0];
				pix_fix_regs_pkg::OFF_AGE: next_s.proc.age = s_axi_wdata[pix_fix_regs_pkg::THR_W-1:0];
				default: begin
				end
			endcase
		end

		// stream monitor: counts and frame tracking
		if (beat) begin
			next_s.pixels = s.pixels + 32'h1;
			if (mon_sof) begin
				next_s.in_frame = 1'b1;
			end
			if (mon_eol) begin
				next_s.pix = '0;
				next_s.lines = s.lines + 32'h1;
				// hold at the overrun point so late starts keep flagging
				next_s.line = (line_n > h14) ? s.line : line_n;
			end else begin
				next_s.pix = (pcnt > w14) ? s.pix : pcnt;
				if (mon_sof) begin
					next_s.line = '0;
				end
			end
			if (ev_done) begin
				next_s.in_frame = 1'b0;
				next_s.frames = s.frames + 32'h1;
				next_s.cands = cand_count_in;
				next_s.fixed = fixed_count_in;
				if (s.control[pix_fix_regs_pkg::CTL_UPD]) begin
					next_s.act = s.proc;
				end
			end
		end

		// sticky flags with write-one clear
		sts_set[pix_fix_regs_pkg::STS_BEGUN] = ev_begun;
		sts_set[pix_fix_regs_pkg::STS_DONE] = ev_done;
		sts_set[pix_fix_regs_pkg::STS_ERR] = |err_ev;
		next_s.status = w1c(s.status, sts_set, sts_clr);
		next_s.errors = 4'(w1c({13'h0, s.errors}, {13'h0, err_ev}, err_clr));

		// unlatched event vector: bits 3 and 2 unused
		next_s.events = {err_ev, |err_ev, 2'b00, ev_done, ev_begun};

		// core reset: counters, tracking, flags and active set
		if (reset_now) begin
			next_s.frames = '0;
			next_s.lines = '0;
			next_s.pixels = '0;
			next_s.cands = '0;
			next_s.fixed = '0;
			next_s.status = '0;
			next_s.errors = '0;
			next_s.events = '0;
			next_s.in_frame = 1'b0;
			next_s.pix = '0;
			next_s.line = '0;
			next_s.act = DEF_CFG;
			next_s.control[pix_fix_regs_pkg::CTL_FSR] = 1'b0;
			if (s.control[pix_fix_regs_pkg::CTL_SRST]) begin
				next_s.proc = DEF_CFG;
			end
		end
		next_s.core_rst = reset_now;

		// level interrupt from masked flags
		next_s.irq = |(next_s.status & next_s.mask);
	end

	// =====================================================
	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.proc <= DEF_CFG;
			s.act <= DEF_CFG;
		end else begin
			s <= next_s;
		end
	end

	// =====================================================
	// outputs
	assign s_axi_awready = s.aw_rdy;
	assign s_axi_wready = s.aw_rdy;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.ar_rdy;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign active_cfg = s.act;
	assign software_run_bit = s.control[pix_fix_regs_pkg::CTL_RUN];
	assign bypass_mode = s.control[pix_fix_regs_pkg::CTL_BYP];
	assign test_pattern_mode = s.control[pix_fix_regs_pkg::CTL_TPG];
	assign core_reset = s.core_rst;
	assign irq = s.irq;
	assign parallel_event_vector = s.events;

	// =====================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_tpg;
		wr_fire && waddr == pix_fix_regs_pkg::OFF_CONTROL
		|=> test_pattern_mode == ($past(s_axi_wdata[pix_fix_regs_pkg::CTL_TPG]) && DEBUG_EN);
	endproperty
	a_tpg: assert property (p_tpg) else $error("test pattern bit wrong");

	property p_srst;
		s.control[pix_fix_regs_pkg::CTL_SRST] |=> s.frames == 32'h0 && s.status == 17'h0 && core_reset;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset not holding");

	property p_fsr;
		s.control[pix_fix_regs_pkg::CTL_FSR] && !s.in_frame && !ev_begun
		|=> !s.control[pix_fix_regs_pkg::CTL_FSR] && core_reset && s.pixels == 32'h0;
	endproperty
	a_fsr: assert property (p_fsr) else $error("frame reset not taken");

	property p_sticky;
		s.status[pix_fix_regs_pkg::STS_BEGUN] && !reset_now &&
		!(wr_fire && waddr == pix_fix_regs_pkg::OFF_STATUS) |=> s.status[pix_fix_regs_pkg::STS_BEGUN];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status flag dropped");

	property p_w1c;
		wr_fire && waddr == pix_fix_regs_pkg::OFF_STATUS && s_axi_wdata[pix_fix_regs_pkg::STS_BEGUN] &&
		!ev_begun && !s_axi_wdata[pix_fix_regs_pkg::STS_DONE] && !reset_now && !ev_done
		|=> !s.status[pix_fix_regs_pkg::STS_BEGUN] &&
		$stable(s.status[pix_fix_regs_pkg::STS_DONE]);
	endproperty
	a_w1c: assert property (p_w1c) else $error("write-one clear wrong");

	property p_begun;
		ev_begun && !reset_now |=> s.status[pix_fix_regs_pkg::STS_BEGUN] &&
		parallel_event_vector[pix_fix_regs_pkg::EV_BEGUN];
	endproperty
	a_begun: assert property (p_begun) else $error("frame start not flagged");

	property p_err;
		err_ev[0] && !reset_now |=> s.errors[0] && s.status[pix_fix_regs_pkg::STS_ERR] &&
		parallel_event_vector[pix_fix_regs_pkg::EV_SHORT] &&
		parallel_event_vector[pix_fix_regs_pkg::EV_ERR];
	endproperty
	a_err: assert property (p_err) else $error("short line not flagged");

	property p_irq;
		irq == |(s.status & s.mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not masked status");

	property p_pulse;
		parallel_event_vector[pix_fix_regs_pkg::EV_DONE] && !ev_done
		|=> !parallel_event_vector[pix_fix_regs_pkg::EV_DONE];
	endproperty
	a_pulse: assert property (p_pulse) else $error("event vector latched");

	property p_shadow;
		beat && !s.control[pix_fix_regs_pkg::CTL_UPD] && !reset_now |=> $stable(s.act);
	endproperty
	a_shadow: assert property (p_shadow) else $error("active set changed");

	// a halted cycle adds no pixel; only a core reset may move the count, and only to zero
	property p_halt;
		!software_run_bit |=> parallel_event_vector == 9'h0 &&
		(s.pixels == $past(s.pixels) || s.pixels == 32'h0);
	endproperty
	a_halt: assert property (p_halt) else $error("monitor ran while halted");

	c_frame: cover property (ev_begun ##[1:300] ev_done);
	c_error: cover property (|err_ev ##1 irq);
	c_fsr: cover property (s.control[pix_fix_regs_pkg::CTL_FSR] ##[1:50] core_reset);

endmodule : video_pixel_fix_ctrl_regs

`default_nettype wire

/* File: pix_fix_host_model.sv */
// host processor model: drives the register bus of the pixel-correction bank
// assumes the bank shares clk; responses are always taken at once
`timescale 1ns/1ps
`default_nettype none

module pix_fix_host_model (
	input wire logic clk,
	output logic awvalid,
	output logic [31:0] awaddr,
	output logic wvalid,
	output logic [31:0] wdata,
	input wire logic awready,
	input wire logic bvalid,
	output logic bready,
	output logic arvalid,
	output logic [31:0] araddr,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	// ==========================================
	// idle bus at time zero, ready always high
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		bready = 1'b1;
		rready = 1'b1;
	end

	// ==========================================
	// one full-word write, held until the address handshake edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		awaddr = {20'h0, a};
		wdata = d;
		awvalid = 1'b1;
		wvalid = 1'b1;
		do @(posedge clk); while (!awready);
		#1;
		awvalid = 1'b0;
		wvalid = 1'b0;
		// released lines show the inverse, not a stale copy
		awaddr = ~awaddr;
		wdata = ~wdata;
		do @(posedge clk); while (!bvalid);
	endtask : wr

	// ==========================================
	// one read, returns at the edge where the data is taken
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		#1;
		araddr = {20'h0, a};
		arvalid = 1'b1;
		do @(posedge clk); while (!arready);
		#1;
		arvalid = 1'b0;
		araddr = ~araddr;
		do @(posedge clk); while (!rvalid);
	endtask : rd
endmodule : pix_fix_host_model
`default_nettype wire

/* File: video_pixel_fix_ctrl_regs_tb_top.sv */
// self-checking bench of the pixel-correction register bank
// assumes the host model file is compiled first; expected results queue up
`timescale 1ns/1ps
`default_nettype none

module video_pixel_fix_ctrl_regs_tb_top;
	localparam logic [31:0] VID = 32'h0a0b_0c0d; // arbitrary value
	localparam logic [12:0] W = 13'h020;
	localparam logic [12:0] H = 13'h020;
	logic clk, rst, awvalid, awready, wvalid, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, cand_in, fixed_in, m;
	logic [1:0] bresp, rresp;
	logic mon_beat, mon_sof, mon_eol, run, byp, tpg, crst, irq, wrdy;
	logic [8:0] pev, pev_seen;
	pix_fix_regs_pkg::cfg_t act;
	logic [1:0] exp_b[$]; // expected write responses
	logic [33:0] exp_r[$]; // expected {resp, data} of reads
	int num_errors, n_tests, seed;

	// ==========================================
	// clock, running from time zero
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	video_pixel_fix_ctrl_regs #(.DEBUG_EN(1'b1), .VERSION_ID(VID), .DEF_WIDTH(W), .DEF_HEIGHT(H),
		.DEF_STUCK(12'h010), .DEF_OUTLIER(16'h0040), .DEF_AGE(16'h03e8)) u_video_pixel_fix_ctrl_regs (
		.clk(clk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_wdata(wdata), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .mon_beat(mon_beat), .mon_sof(mon_sof), .mon_eol(mon_eol),
		.cand_count_in(cand_in), .fixed_count_in(fixed_in), .active_cfg(act), .software_run_bit(run),
		.bypass_mode(byp), .test_pattern_mode(tpg), .core_reset(crst), .irq(irq),
		.parallel_event_vector(pev));

	pix_fix_host_model u_pix_fix_host_model (.clk(clk), .awvalid(awvalid), .awaddr(awaddr),
		.wvalid(wvalid), .wdata(wdata), .awready(awready), .bvalid(bvalid), .bready(bready),
		.arvalid(arvalid), .araddr(araddr), .arready(arready), .rvalid(rvalid), .rready(rready));

	// ==========================================
	// comparison and verdict
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// monitor: each response takes the oldest note off its queue
	always @(posedge clk) begin
		if (bvalid && bready) begin
			chk({bresp, 32'h0}, {exp_b.pop_front(), 32'h0});
		end
		if (rvalid && rready) begin
			chk({rresp, rdata}, exp_r.pop_front());
		end
		// data ready must pulse together with address ready
		if (awready) begin
			chk({33'h0, wrdy}, 34'h1);
		end
	end

	// collects event pulses between clears; cleared in reset so no unknown lingers
	always @(posedge clk) pev_seen <= rst ? 9'h000 : (pev_seen | pev);

	// ==========================================
	// bus and stream helpers
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		exp_b.push_back(r);
		u_pix_fix_host_model.wr(a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		exp_r.push_back({r, d});
		u_pix_fix_host_model.rd(a);
	endtask : rd

	task automatic flag(input logic v, input logic e);
		chk({33'h0, v}, {33'h0, e});
	endtask : flag

	// n stream beats, sof on the first, eol on the last if asked
	task automatic beats(input int n, input logic sof, input logic eol);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			mon_beat = 1'b1;
			mon_sof = sof && i == 0;
			mon_eol = eol && i == n - 1;
		end
		@(posedge clk);
		#1;
		mon_beat = 1'b0;
		mon_sof = 1'b0;
		mon_eol = 1'b0;
	endtask : beats

	task automatic lines(input int n, input logic sof);
		for (int l = 0; l < n; l++) begin
			beats(W, sof && l == 0, 1'b1);
		end
	endtask : lines

	// ==========================================
	// watchdog
	initial begin
		#2_000_000;
		num_errors++;
		end_of_test();
	end

	// ==========================================
	// main sequence
	initial begin
		seed = 76074;
		rst = 1'b1;
		mon_beat = 1'b0;
		mon_sof = 1'b0;
		mon_eol = 1'b0;
		pev_seen = 9'h000;
		cand_in = $random(seed);
		fixed_in = $random(seed);
		m = $random(seed);
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		// reset values and an unmapped offset
		rd(pix_fix_regs_pkg::OFF_CONTROL, 32'h0);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0);
		rd(pix_fix_regs_pkg::OFF_ERRORS, 32'h0);
		rd(pix_fix_regs_pkg::OFF_VERSION, VID);
		rd(pix_fix_regs_pkg::OFF_PIXELS, 32'h0);
		rd(pix_fix_regs_pkg::OFF_DIMS, {3'h0, H, 3'h0, W});
		rd(pix_fix_regs_pkg::OFF_AGE, 32'h0000_03e8);
		rd(12'h200, 32'h0, pix_fix_regs_pkg::RESP_SLVERR);
		wr(pix_fix_regs_pkg::OFF_MASK, m);
		rd(pix_fix_regs_pkg::OFF_MASK, m & 32'h0001_ffff);
		// one whole frame with a staged threshold and update bit
		wr(pix_fix_regs_pkg::OFF_MASK, 32'h0000_0003);
		wr(pix_fix_regs_pkg::OFF_STUCK, 32'h0000_0005);
		wr(pix_fix_regs_pkg::OFF_CONTROL, 32'h0000_0003);
		chk({22'h0, act.stuck}, 34'h010);
		lines(H, 1'b1);
		repeat (3) @(posedge clk);
		chk({25'h0, pev_seen}, 34'h003);
		flag(pev === 9'h000, 1'b1);
		chk({22'h0, act.stuck}, 34'h005);
		chk({18'h0, act.outlier}, 34'h0040);
		chk({18'h0, act.age}, 34'h03e8);
		chk({21'h0, act.width}, {21'h0, W});
		flag(irq, 1'b1);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0000_0003);
		rd(pix_fix_regs_pkg::OFF_FRAMES, 32'h1);
		rd(pix_fix_regs_pkg::OFF_LINES, {19'h0, H});
		rd(pix_fix_regs_pkg::OFF_PIXELS, {19'h0, W} * {19'h0, H});
		rd(pix_fix_regs_pkg::OFF_CANDS, cand_in);
		rd(pix_fix_regs_pkg::OFF_FIXED, fixed_in);
		// status: zero leaves flags, one clears only its own
		wr(pix_fix_regs_pkg::OFF_STATUS, 32'h0);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0000_0003);
		wr(pix_fix_regs_pkg::OFF_STATUS, 32'h0000_0001);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0000_0002);
		flag(irq, 1'b1);
		wr(pix_fix_regs_pkg::OFF_STATUS, 32'h0000_0002);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0);
		flag(irq, 1'b0);
		// framing faults: short line, early start, long line
		wr(pix_fix_regs_pkg::OFF_MASK, 32'h0001_0000);
		// clear off the edge so the collector's own update cannot undo it
		#1;
		pev_seen = 9'h000;
		beats(1, 1'b1, 1'b0);
		beats(9, 1'b0, 1'b1);
		beats(1, 1'b1, 1'b0);
		beats(W + 1, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		chk({25'h0, pev_seen}, 34'h0f1);
		flag(irq, 1'b1);
		rd(pix_fix_regs_pkg::OFF_ERRORS, 32'h0000_0007);
		wr(pix_fix_regs_pkg::OFF_ERRORS, 32'h0000_0001);
		rd(pix_fix_regs_pkg::OFF_ERRORS, 32'h0000_0006);
		wr(pix_fix_regs_pkg::OFF_ERRORS, 32'h0000_0006);
		rd(pix_fix_regs_pkg::OFF_STATUS, 32'h0001_0001);
		// immediate soft reset with test pattern, shadow back to defaults
		wr(pix_fix_regs_pkg::OFF_DIMS, 32'h0040_0040);
		wr(pix_fix_regs_pkg::OFF_CONTROL, 32'h8000_0031);
		repeat (3) @(posedge clk);
		flag(crst, 1'b1);
		flag(tpg, 1'b1);
		flag(byp, 1'b1);
		flag(run, 1'b1);
		beats(4, 1'b1, 1'b0);
		rd(pix_fix_regs_pkg::OFF_PIXELS, 32'h0);
		rd(pix_fix_regs_pkg::OFF_DIMS, {3'h0, H, 3'h0, W});
		// run bit low ignores beats
		wr(pix_fix_regs_pkg::OFF_CONTROL, 32'h0);
		flag(run, 1'b0);
		flag(tpg, 1'b0);
		beats(4, 1'b1, 1'b0);
		rd(pix_fix_regs_pkg::OFF_PIXELS, 32'h0);
		// frame-synchronised reset waits for the frame to end
		wr(pix_fix_regs_pkg::OFF_CONTROL, 32'h0000_0001);
		beats(4, 1'b1, 1'b0);
		wr(pix_fix_regs_pkg::OFF_CONTROL, 32'h4000_0001);
		rd(pix_fix_regs_pkg::OFF_CONTROL, 32'h4000_0001);
		rd(pix_fix_regs_pkg::OFF_PIXELS, 32'h4);
		beats(W - 4, 1'b0, 1'b1);
		lines(H - 1, 1'b0);
		repeat (3) @(posedge clk);
		rd(pix_fix_regs_pkg::OFF_CONTROL, 32'h0000_0001);
		rd(pix_fix_regs_pkg::OFF_FRAMES, 32'h0);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : video_pixel_fix_ctrl_regs_tb_top
`default_nettype wire
